// [card_link_pkg.sv]
/*
 * Shared constants and types for the card-side flag handshake block:
 * register map, field positions, query byte layout and timing counts.
 * Assumes a 100 MHz hclk.
 */
`default_nettype none
package card_link_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned READY_TIME_S   = 5;
   // longest time: exact whole-cycle product
   localparam int unsigned READY_CYCLES   = READY_TIME_S * CLK_HZ;

   // ==========================================================
   // buffers
   localparam int unsigned BUF_DEPTH      = 4096;
   localparam int unsigned BUF_AW         = 12;
   localparam int unsigned LEN_W          = 16;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL        = 8'h00;
   localparam logic [7:0] OFS_STATUS      = 8'h04;
   localparam logic [7:0] OFS_TXLEN       = 8'h08;
   localparam logic [7:0] OFS_TXDATA      = 8'h0C;
   localparam logic [7:0] OFS_RXDATA      = 8'h10;
   localparam logic [7:0] OFS_RXLEN       = 8'h14;
   localparam logic [7:0] OFS_EXT         = 8'h18;
   localparam logic [7:0] OFS_SESSION     = 8'h1C;

   // ctrl fields
   localparam int unsigned CTRL_IE_DA     = 0;
   localparam int unsigned CTRL_IE_FR     = 1;
   localparam int unsigned CTRL_IE_XDA    = 2;
   localparam int unsigned CTRL_IE_XFR    = 3;
   localparam int unsigned CTRL_ERR       = 4;
   localparam int unsigned CTRL_W         = 5;
   localparam logic [4:0]  CTRL_RST       = 5'h00;
   // ext fields
   localparam int unsigned EXT_DA         = 0;
   localparam int unsigned EXT_FR         = 1;
   // session fields
   localparam int unsigned SES_TIME       = 0;
   localparam int unsigned SES_EXT        = 1;
   // status fields
   localparam int unsigned ST_READY       = 0;
   localparam int unsigned ST_TXPEND      = 1;
   localparam int unsigned ST_RXBUSY      = 2;
   localparam int unsigned ST_STARTED     = 3;
   localparam int unsigned ST_IRQ         = 4;
   localparam int unsigned ST_HQ_LO       = 8;

   // header byte positions within a frame
   localparam logic [1:0] IDX_QUERY       = 2'h0;
   localparam logic [1:0] IDX_LEN_MSB     = 2'h1;
   localparam logic [1:0] IDX_LEN_LSB     = 2'h2;

   // query byte, bit 7 down to bit 0
   typedef struct packed {
      logic spare_hi;
      logic ready;
      logic channel_select_flag;
      logic last;
      logic first;
      logic data_waiting_flag;
      logic error_flag;
      logic spare_lo;
   } query_t;

   typedef enum logic [1:0] {LK_IDLE, LK_HEAD, LK_DATA} link_st_t;

   function automatic logic [LEN_W-1:0] max_len(
      input logic [LEN_W-1:0] a,
      input logic [LEN_W-1:0] b);
      max_len = (a > b) ? a : b;
   endfunction
endpackage
`default_nettype wire

// [card_byte_buf.sv]
/*
 * Byte buffer, one write port and one registered read port.
 * Read address is expected to be the next pointer value so that data
 * for the new pointer is available on the same edge that loads the pointer.
 */
`default_nettype none
module card_byte_buf (
   input  wire logic                                hclk,
   input  wire logic                                we,
   input  wire logic [card_link_pkg::BUF_AW-1:0]    waddr,
   input  wire logic [7:0]                          wdata,
   input  wire logic [card_link_pkg::BUF_AW-1:0]    raddr,
   output logic      [7:0]                          rdata
);
   logic [7:0] mem [card_link_pkg::BUF_DEPTH];

   always_ff @(posedge hclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// [card_ready_timer.sv]
/*
 * Start-up timer: counts cycles after reset release and raises done
 * once the count is reached. Assumes hresetn is async, active low.
 */
`default_nettype none
module card_ready_timer #(
   parameter int unsigned CYCLES = card_link_pkg::READY_CYCLES
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   output logic      done_r
);
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic        done_nxt;

   always_comb begin
      cnt_nxt  = cnt_r;
      done_nxt = done_r;
      if (!done_r) begin
         cnt_nxt = cnt_r + 32'h0000_0001;
         if (cnt_nxt >= CYCLES) begin
            done_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r  <= 32'h0000_0000;
         done_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         done_r <= done_nxt;
      end
   end
endmodule
`default_nettype wire

// [card_flag_link.sv]
/*
 * Card-side flag handshake of the host command interface: query byte,
 * two length bytes and polled data bytes, receive and transmit buffers,
 * extended channel flags and the shared interrupt line, with an
 * AHB-Lite register slave for the card firmware.
 * Assumes link strobes synchronous to hclk and at least one idle cycle
 * between two host_byte_valid pulses.
 */
`default_nettype none
// Overview of operation
// - interrupt when enabled waiting or free flag set
// - both channel interrupts ORed onto one line
// - card sends data only after host poll
// - either side may use extended channel anytime
// - card raises ready within five seconds
// - queued message: waiting set, select clear, length
// - card captures host data bytes only if receive buffer was free at query
// - card ready low while processing received message
// - queued inquiry: ready and waiting raised together; code keeps ready low while rxb_r is set
// - exactly one system time session opened
// - extended support session never closed
module card_flag_link #(
   parameter int unsigned READY_CYCLES = card_link_pkg::READY_CYCLES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata_r,
   output logic             hreadyout_r,
   output logic             hresp_r,
   input  wire logic        frame_start,
   input  wire logic        host_byte_valid,
   input  wire logic [7:0]  host_byte,
   output logic      [7:0]  card_byte_r,
   output logic             card_byte_valid_r,
   output logic             card_irq_r
);
   localparam int unsigned AW = card_link_pkg::BUF_AW;
   localparam int unsigned LW = card_link_pkg::LEN_W;

   // ==========================================================
   // state
   card_link_pkg::link_st_t   st_r, st_nxt;
   logic [1:0]                idx_r, idx_nxt;
   logic [LW-1:0]             dcnt_r, dcnt_nxt, total_r, total_nxt;
   card_link_pkg::query_t     hq_r, hq_nxt;
   logic [LW-1:0]             hlen_r, hlen_nxt;
   logic                      sent_r, sent_nxt, rxok_r, rxok_nxt;
   logic                      txp_r, txp_nxt, rxb_r, rxb_nxt;
   logic [LW-1:0]             txlen_r, txlen_nxt, rxlen_r, rxlen_nxt;
   logic [AW-1:0]             txw_r, txw_nxt, txr_r, txr_nxt;
   logic [AW-1:0]             rxr_r, rxr_nxt;
   logic [card_link_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
   logic [1:0]                ext_r, ext_nxt, ses_r, ses_nxt;
   logic [7:0]                cb_nxt;
   logic                      cbv_nxt, irq_nxt;
   logic                      wr_pend_r, wr_pend_nxt;
   logic [7:0]                wr_ofs_r, wr_ofs_nxt;
   logic [31:0]               rd_nxt;
   logic                      tx_we, rx_we;
   logic [7:0]                tx_rdata, rx_rdata;
   logic                      started, card_ready, irq_term, rd_go;
   logic [LW-1:0]             hlen_full;
   card_link_pkg::query_t     cq;

   card_ready_timer #(.CYCLES(READY_CYCLES)) u_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .done_r  (started)
   );

   card_byte_buf u_txbuf (
      .hclk  (hclk),
      .we    (tx_we),
      .waddr (txw_r),
      .wdata (hwdata[7:0]),
      .raddr (txr_nxt),
      .rdata (tx_rdata)
   );

   card_byte_buf u_rxbuf (
      .hclk  (hclk),
      .we    (rx_we),
      .waddr (dcnt_r[AW-1:0]),
      .wdata (host_byte),
      .raddr (rxr_nxt),
      .rdata (rx_rdata)
   );

   // ==========================================================
   // flags
   assign card_ready = started & ~rxb_r;
   assign irq_term = (txp_r & ctrl_r[card_link_pkg::CTRL_IE_DA])
      | (~rxb_r & ctrl_r[card_link_pkg::CTRL_IE_FR])
      | (ext_r[card_link_pkg::EXT_DA] & ctrl_r[card_link_pkg::CTRL_IE_XDA])
      | (ext_r[card_link_pkg::EXT_FR] & ctrl_r[card_link_pkg::CTRL_IE_XFR]);
   assign hlen_full = {hlen_r[7:0], host_byte};
   assign rd_go = hsel & htrans[1] & hready & ~hwrite;

   always_comb begin
      cq                     = '0;
      cq.ready               = card_ready;
      cq.channel_select_flag = 1'b0;
      cq.data_waiting_flag   = txp_r;
      cq.first               = txp_r;
      cq.last                = txp_r;
      cq.error_flag          = ctrl_r[card_link_pkg::CTRL_ERR];
   end

   // ==========================================================
   // link sequencing
   always_comb begin
      st_nxt    = st_r;
      idx_nxt   = idx_r;
      dcnt_nxt  = dcnt_r;
      total_nxt = total_r;
      hq_nxt    = hq_r;
      hlen_nxt  = hlen_r;
      sent_nxt  = sent_r;
      rxok_nxt  = rxok_r;
      txr_nxt   = txr_r;
      cb_nxt    = card_byte_r;
      cbv_nxt   = 1'b0;
      rx_we     = 1'b0;
      txp_nxt   = txp_r;
      rxb_nxt   = rxb_r;
      rxlen_nxt = rxlen_r;
      rxr_nxt   = rxr_r;
      if (frame_start) begin
         st_nxt  = card_link_pkg::LK_HEAD;
         idx_nxt = card_link_pkg::IDX_QUERY;
      end else if (host_byte_valid && st_r != card_link_pkg::LK_IDLE) begin
         cbv_nxt = 1'b1;
         unique case (st_r)
            card_link_pkg::LK_HEAD: begin
               idx_nxt = idx_r + 2'h1;
               unique case (idx_r)
                  card_link_pkg::IDX_QUERY: begin
                     cb_nxt   = cq;
                     hq_nxt   = host_byte;
                     sent_nxt = txp_r;
                     rxok_nxt = ~rxb_r;
                     txr_nxt  = '0;
                  end
                  card_link_pkg::IDX_LEN_MSB: begin
                     cb_nxt   = sent_r ? txlen_r[15:8] : 8'h00;
                     hlen_nxt = {8'h00, host_byte};
                  end
                  default: begin
                     cb_nxt   = sent_r ? txlen_r[7:0] : 8'h00;
                     hlen_nxt = hlen_full;
                     dcnt_nxt = '0;
                     total_nxt = card_link_pkg::max_len(
                        sent_r ? txlen_r : '0,
                        hq_r.data_waiting_flag ? hlen_full : '0);
                     st_nxt = (total_nxt == '0) ? card_link_pkg::LK_IDLE
                                                : card_link_pkg::LK_DATA;
                  end
               endcase
            end
            card_link_pkg::LK_DATA: begin
               cb_nxt = 8'h00;
               if (sent_r && dcnt_r < txlen_r) begin
                  cb_nxt  = tx_rdata;
                  txr_nxt = txr_r + AW'(1);
               end
               if (rxok_r && hq_r.data_waiting_flag
                   && !hq_r.channel_select_flag && dcnt_r < hlen_r) begin
                  rx_we = 1'b1;
               end
               dcnt_nxt = dcnt_r + LW'(1);
               if (dcnt_nxt == total_r) begin
                  st_nxt = card_link_pkg::LK_IDLE;
                  if (sent_r) begin
                     txp_nxt = 1'b0;
                  end
                  if (rxok_r && hq_r.data_waiting_flag
                      && !hq_r.channel_select_flag) begin
                     rxb_nxt   = 1'b1;
                     rxlen_nxt = hlen_r;
                     rxr_nxt   = '0;
                  end
               end
            end
            default: begin
               st_nxt = card_link_pkg::LK_IDLE;
            end
         endcase
      end
      // firmware side effects
      if (rd_go && haddr[7:0] == card_link_pkg::OFS_RXDATA) begin
         rxr_nxt = rxr_r + AW'(1);
      end
      if (wr_pend_r && wr_ofs_r == card_link_pkg::OFS_TXLEN && !txp_r) begin
         txp_nxt = 1'b1;
      end
      // release only a busy buffer: a frame that fills it keeps busy
      if (wr_pend_r && wr_ofs_r == card_link_pkg::OFS_RXLEN && rxb_r) begin
         rxb_nxt = 1'b0;
         rxr_nxt = '0;
      end
   end

   // ==========================================================
   // register slave
   always_comb begin
      wr_pend_nxt = hsel & htrans[1] & hready & hwrite;
      wr_ofs_nxt  = haddr[7:0];
      ctrl_nxt    = ctrl_r;
      txlen_nxt   = txlen_r;
      txw_nxt     = txw_r;
      ext_nxt     = ext_r;
      ses_nxt     = ses_r;
      tx_we       = 1'b0;
      irq_nxt     = irq_term;
      rd_nxt      = 32'h0000_0000;
      if (wr_pend_r) begin
         unique case (wr_ofs_r)
            card_link_pkg::OFS_CTRL:
               ctrl_nxt = hwdata[card_link_pkg::CTRL_W-1:0];
            card_link_pkg::OFS_TXLEN: begin
               if (!txp_r) begin
                  txlen_nxt = hwdata[LW-1:0];
                  txw_nxt   = '0;
               end
            end
            card_link_pkg::OFS_TXDATA: begin
               if (!txp_r) begin
                  tx_we   = 1'b1;
                  txw_nxt = txw_r + AW'(1);
               end
            end
            card_link_pkg::OFS_EXT: ext_nxt = hwdata[1:0];
            card_link_pkg::OFS_SESSION:
               ses_nxt = ses_r | hwdata[1:0];
            default: ;
         endcase
      end
      if (rd_go) begin
         unique case (haddr[7:0])
            card_link_pkg::OFS_CTRL:
               rd_nxt[card_link_pkg::CTRL_W-1:0] = ctrl_r;
            card_link_pkg::OFS_STATUS: begin
               rd_nxt[card_link_pkg::ST_READY]   = card_ready;
               rd_nxt[card_link_pkg::ST_TXPEND]  = txp_r;
               rd_nxt[card_link_pkg::ST_RXBUSY]  = rxb_r;
               rd_nxt[card_link_pkg::ST_STARTED] = started;
               rd_nxt[card_link_pkg::ST_IRQ]     = card_irq_r;
               rd_nxt[card_link_pkg::ST_HQ_LO +: 8] = hq_r;
            end
            card_link_pkg::OFS_TXLEN:   rd_nxt[LW-1:0] = txlen_r;
            card_link_pkg::OFS_RXDATA:  rd_nxt[7:0]    = rx_rdata;
            card_link_pkg::OFS_RXLEN:   rd_nxt[LW-1:0] = rxlen_r;
            card_link_pkg::OFS_EXT:     rd_nxt[1:0]    = ext_r;
            card_link_pkg::OFS_SESSION: rd_nxt[1:0]    = ses_r;
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= card_link_pkg::LK_IDLE;
         idx_r <= 2'h0;
         dcnt_r <= '0;
         total_r <= '0;
         hq_r <= '0;
         hlen_r <= '0;
         sent_r <= 1'b0;
         rxok_r <= 1'b0;
         txr_r <= '0;
         card_byte_r <= 8'h00;
         card_byte_valid_r <= 1'b0;
         txp_r <= 1'b0;
         rxb_r <= 1'b0;
         rxlen_r <= '0;
         rxr_r <= '0;
         wr_pend_r <= 1'b0;
         wr_ofs_r <= 8'h00;
         ctrl_r <= card_link_pkg::CTRL_RST;
         txlen_r <= '0;
         txw_r <= '0;
         ext_r <= 2'h0;
         ses_r <= 2'h0;
         card_irq_r <= 1'b0;
         hrdata_r <= 32'h0000_0000;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         idx_r <= idx_nxt;
         dcnt_r <= dcnt_nxt;
         total_r <= total_nxt;
         hq_r <= hq_nxt;
         hlen_r <= hlen_nxt;
         sent_r <= sent_nxt;
         rxok_r <= rxok_nxt;
         txr_r <= txr_nxt;
         card_byte_r <= cb_nxt;
         card_byte_valid_r <= cbv_nxt;
         txp_r <= txp_nxt;
         rxb_r <= rxb_nxt;
         rxlen_r <= rxlen_nxt;
         rxr_r <= rxr_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_ofs_r <= wr_ofs_nxt;
         ctrl_r <= ctrl_nxt;
         txlen_r <= txlen_nxt;
         txw_r <= txw_nxt;
         ext_r <= ext_nxt;
         ses_r <= ses_nxt;
         card_irq_r <= irq_nxt;
         hrdata_r <= rd_nxt;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic [31:0] since_rst_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         since_rst_r <= 32'h0000_0000;
      end else if (!started) begin
         since_rst_r <= since_rst_r + 32'h0000_0001;
      end
   end

   // host data bytes written since the last frame start
   logic [LW-1:0] cap_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cap_r <= '0;
      end else if (frame_start) begin
         cap_r <= '0;
      end else if (rx_we) begin
         cap_r <= cap_r + LW'(1);
      end
   end

   sequence query_byte_s;
      host_byte_valid && !frame_start && st_r == card_link_pkg::LK_HEAD
         && idx_r == card_link_pkg::IDX_QUERY;
   endsequence

   irq_combine_a: assert property (irq_term |=> card_irq_r)
      else $error("enabled flag did not raise interrupt");
   irq_quiet_a: assert property (!irq_term |=> !card_irq_r)
      else $error("interrupt without enabled flag");
   polled_only_a: assert property (
      card_byte_valid_r |-> $past(host_byte_valid))
      else $error("card byte without host poll");
   ready_time_a: assert property (
      !started |-> since_rst_r < READY_CYCLES)
      else $error("card ready late after reset");
   busy_ready_a: assert property (query_byte_s and rxb_r
      |=> !card_byte_r[6])
      else $error("ready while processing receive buffer");
   query_flags_a: assert property (
      query_byte_s and txp_r && started && !rxb_r
      |=> card_byte_r[6] && !card_byte_r[5] && card_byte_r[2])
      else $error("queued message flags wrong in query");
   frag_flags_a: assert property (query_byte_s and txp_r
      |=> card_byte_r[4] && card_byte_r[3])
      else $error("first or last missing on whole message");
   query_layout_a: assert property (query_byte_s
      |=> !card_byte_r[7] && !card_byte_r[0])
      else $error("ignored query bits not zero");
   rx_capture_a: assert property ($rose(rxb_r) |-> cap_r == rxlen_r)
      else $error("host byte not captured");
   time_once_a: assert property (
      $past(ses_r[card_link_pkg::SES_TIME])
      |-> ses_r[card_link_pkg::SES_TIME])
      else $error("time session closed");
   ext_keep_a: assert property (
      $past(ses_r[card_link_pkg::SES_EXT])
      |-> ses_r[card_link_pkg::SES_EXT])
      else $error("extended session closed");
   ext_peer_a: assert property (wr_pend_r && wr_ofs_r == card_link_pkg::OFS_EXT
      |=> ext_r == $past(hwdata[1:0]))
      else $error("extended flags not taken at once");
endmodule
`default_nettype wire

// [card_flag_link_pkgless_note_unused.sv]
`default_nettype none
`default_nettype wire

// [host_poller.sv]
/* Host-side model of the polled link: frames, bytes, answer capture.
   Assumes the card answers each byte one cycle after its strobe. */
`default_nettype none
module host_poller (
   input  wire logic       hclk,
   input  wire logic       card_byte_valid_r,
   input  wire logic [7:0] card_byte_r,
   output logic            frame_start,
   output logic            host_byte_valid,
   output logic      [7:0] host_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx [0:15];
   int         strobes;
   initial begin
      frame_start = 1'b0;
      host_byte_valid = 1'b0;
      host_byte = 8'h00;
      strobes = 0;
   end
   always @(posedge hclk) begin
      if (card_byte_valid_r) strobes++;
   end
   // one byte, then release the line to its inverse
   task automatic xfer(input logic [7:0] b, input int k);
      @(posedge hclk);
      host_byte_valid <= 1'b1;
      host_byte <= b;
      @(posedge hclk);
      host_byte_valid <= 1'b0;
      host_byte <= ~b;
      rx[k] = 8'hEE;
      repeat (4) begin
         @(posedge hclk);
         if (card_byte_valid_r === 1'b1) begin
            rx[k] = card_byte_r;
            break;
         end
      end
   endtask
   // poll frame: query, length, then exactly n data bytes
   task automatic frame(input logic [7:0] q, input logic [15:0] len,
                        input int n);
      @(posedge hclk);
      frame_start <= 1'b1;
      @(posedge hclk);
      frame_start <= 1'b0;
      xfer(q, 0);
      xfer(len[15:8], 1);
      xfer(len[7:0], 2);
      for (int i = 0; i < n; i++) xfer(8'hA0 + 8'(i), 3 + i);
   endtask
endmodule
`default_nettype wire

// [card_channel_flag_handshake_test.sv]
/* Self-checking bench for card_flag_link: AHB-Lite master tasks and
   one task per scenario. Assumes host_poller drives the link side. */
`default_nettype none
module card_channel_flag_handshake_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk, hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hrdata_r;
   logic        hreadyout_r, hresp_r, card_byte_valid_r, card_irq_r;
   logic        frame_start, host_byte_valid;
   logic [7:0]  card_byte_r, host_byte;
   logic [6:0]  tv [7];
   int          mismatches, n_tests, total;
   card_flag_link #(.READY_CYCLES(20)) uut (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout_r), .hrdata_r(hrdata_r),
      .hreadyout_r(hreadyout_r), .hresp_r(hresp_r),
      .frame_start(frame_start), .host_byte_valid(host_byte_valid),
      .host_byte(host_byte), .card_byte_r(card_byte_r),
      .card_byte_valid_r(card_byte_valid_r), .card_irq_r(card_irq_r));
   host_poller host (.hclk(hclk), .card_byte_valid_r(card_byte_valid_r),
      .card_byte_r(card_byte_r), .frame_start(frame_start),
      .host_byte_valid(host_byte_valid), .host_byte(host_byte));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      #300000;
      mismatches++;
      summarize();
   end
   task automatic summarize;
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   // ==========================================================
   // bus master
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout_r !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout_r !== 1'b1);
      q = hrdata_r;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      ahb(1'b0, a, 32'h00000000);
   endtask
   task automatic poll(input logic [7:0] qb, input logic [15:0] len,
                       input int n);
      host.frame(qb, len, n);
      total += n + 3;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_start;
      poll(8'h40, 16'h0000, 0);
      chk("query early", host.rx[0], 8'h00);
      repeat (20) @(posedge hclk);
      rd(card_link_pkg::OFS_STATUS);
      chk("ready", q[0], 1'b1);
      poll(8'h40, 16'h0000, 0);
      chk("query idle", host.rx[0], 8'h40);
      $display("start done");
   endtask
   task automatic t_tx;
      for (int i = 0; i < 6; i++)
         wr(card_link_pkg::OFS_TXDATA, 32'h30 + i);
      wr(card_link_pkg::OFS_TXLEN, 32'h6);
      rd(card_link_pkg::OFS_STATUS);
      chk("pending", q[1], 1'b1);
      poll(8'h40, 16'h0000, 6);
      chk("tx query", host.rx[0], 8'h5C);
      chk("tx len", {host.rx[1], host.rx[2]}, 16'h0006);
      for (int i = 0; i < 6; i++)
         chk("tx data", host.rx[3+i], 8'h30 + i);
      rd(card_link_pkg::OFS_STATUS);
      chk("sent", q[1], 1'b0);
      $display("tx done");
   endtask
   task automatic t_rx;
      poll(8'h5C, 16'h0009, 9);
      chk("rx query", host.rx[0], 8'h40);
      rd(card_link_pkg::OFS_STATUS);
      chk("busy", q[2:0], 3'h4);
      chk("host query", q[15:8], 8'h5C);
      poll(8'h40, 16'h0000, 0);
      chk("not ready", host.rx[0], 8'h00);
      rd(card_link_pkg::OFS_RXLEN);
      chk("rx len", q, 32'h9);
      for (int i = 0; i < 9; i++) begin
         rd(card_link_pkg::OFS_RXDATA);
         chk("rx data", q, 32'hA0 + i);
      end
      wr(card_link_pkg::OFS_RXLEN, 32'h0);
      rd(card_link_pkg::OFS_STATUS);
      chk("ready back", q[2:0], 3'h1);
      $display("rx done");
   endtask
   // table of {enables, ext flags, expected line}
   task automatic t_irq;
      tv = '{7'h11, 7'h40, 7'h45, 7'h24, 7'h23, 7'h0E, 7'h06};
      for (int i = 0; i < 7; i++) begin
         wr(card_link_pkg::OFS_EXT, 32'(tv[i][2:1]));
         wr(card_link_pkg::OFS_CTRL, 32'(tv[i][6:3]));
         repeat (3) @(posedge hclk);
         chk("irq", card_irq_r, tv[i][0]);
         rd(card_link_pkg::OFS_STATUS);
         chk("irq status", q[4], tv[i][0]);
         rd(card_link_pkg::OFS_EXT);
         chk("ext", q[1:0], tv[i][2:1]);
      end
      wr(card_link_pkg::OFS_TXDATA, 32'h77);
      wr(card_link_pkg::OFS_TXLEN, 32'h1);
      wr(card_link_pkg::OFS_CTRL, 32'h1);
      repeat (3) @(posedge hclk);
      chk("irq waiting", card_irq_r, 1'b1);
      poll(8'h40, 16'h0000, 1);
      repeat (3) @(posedge hclk);
      chk("irq drained", card_irq_r, 1'b0);
      $display("irq done");
   endtask
   task automatic t_misc;
      rd(8'h20);
      chk("unmapped", q, 32'h0);
      wr(card_link_pkg::OFS_SESSION, 32'h1);
      wr(card_link_pkg::OFS_SESSION, 32'h2);
      wr(card_link_pkg::OFS_SESSION, 32'h0);
      rd(card_link_pkg::OFS_SESSION);
      chk("sessions", q, 32'h3);
      poll(8'h00, 16'h0000, 0);
      chk("host not ready", host.rx[0], 8'h40);
      wr(card_link_pkg::OFS_CTRL, 32'h10);
      poll(8'h40, 16'h0000, 0);
      chk("error bit", host.rx[0], 8'h42);
      chk("okay", hresp_r, 1'b0);
      @(posedge hclk);
      chk("strobes", host.strobes, total);
      $display("misc done");
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      htrans = 2'h0;
      hsize = 3'h2;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_start();
      t_tx();
      t_rx();
      t_irq();
      t_misc();
      summarize();
   end
endmodule
`default_nettype wire
